// [design/rmirq_pkg.sv]
package rmirq_pkg;

    // ****************************************
    // Widths and counts
    // ****************************************
    localparam int          RMIRQ_NUM_LINES  = 4;      // Four shared mode/request pins
    localparam int          RMIRQ_MODE_W     = 4;      // Sixteen boot modes
    localparam int          RMIRQ_PHASE_W    = 2;      // Phase generator width
    localparam logic [3:0]  RMIRQ_MODE_RST   = 4'h0;   // Mode register value while in reset
    localparam logic [1:0]  RMIRQ_PHASE_RST  = 2'h0;   // Phase generator restart value
    localparam logic [3:0]  RMIRQ_LINES_IDLE = 4'hF;   // Request pins idle high
    localparam int          RMIRQ_FIRST_LINE = 0;      // Line that also wakes from stop

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0]
    {
        RMIRQ_ST_RESET = 3'h1,
        RMIRQ_ST_LATCH = 3'h2,
        RMIRQ_ST_RUN   = 3'h4
    } rmirq_state_t;

    // Per-line interrupt configuration
    typedef struct packed
    {
        logic [3:0] enable;     // 1 = request may be raised
        logic [3:0] edge_mode;  // 1 = falling edge, 0 = low level
    } rmirq_cfg_t;

    // Standby state of the core
    typedef struct packed
    {
        logic in_stop;
        logic in_wait;
    } rmirq_standby_t;

endpackage

// [design/rmirq_top.sv]
`timescale 1ns/1ps

// Overview of operation
// - Four mode pins form a 4-bit code, latched into mode register at reset release.
// - After reset release the same four pins act as interrupt request lines.
// - Each request is selectable as low level or falling edge; enable masks its pending flag but not wake.
// - First request line wakes the core from either stop or wait.
// - Second to fourth request lines wake the core from wait only.
// - Reset holds the chip in reset and restarts the phase generator.
module rmirq_top
    import rmirq_pkg::*;
(
    input  wire logic                        I_CLK,
    input  wire logic                        I_RST,
    input  wire logic [RMIRQ_NUM_LINES-1:0]  I_MODE_PINS,
    input  wire rmirq_cfg_t                  I_CFG,
    input  wire logic [RMIRQ_NUM_LINES-1:0]  I_INT_ACK,
    input  wire rmirq_standby_t              I_STANDBY,
    output logic [RMIRQ_MODE_W-1:0]          O_OP_MODE,
    output logic                             O_MODE_VALID,
    output logic [RMIRQ_NUM_LINES-1:0]       O_INT_PEND,
    output logic                             O_WAKE,
    output logic                             O_CHIP_RESET,
    output logic [RMIRQ_PHASE_W-1:0]         O_PHASE
);

    // ****************************************
    // Helper functions
    // ****************************************
    // Falling edge of an active-low line
    function automatic logic [RMIRQ_NUM_LINES-1:0] fall_det
    (
        input logic [RMIRQ_NUM_LINES-1:0] prev,
        input logic [RMIRQ_NUM_LINES-1:0] curr
    );
        fall_det = prev & ~curr;
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    logic [RMIRQ_NUM_LINES-1:0] sync1_r;
    logic [RMIRQ_NUM_LINES-1:0] sync1_nxt;
    logic [RMIRQ_NUM_LINES-1:0] sync2_r;
    logic [RMIRQ_NUM_LINES-1:0] sync2_nxt;
    logic [RMIRQ_NUM_LINES-1:0] prev_r;
    logic [RMIRQ_NUM_LINES-1:0] prev_nxt;
    rmirq_state_t               state_r;
    rmirq_state_t               state_nxt;
    logic [RMIRQ_MODE_W-1:0]    mode_r;
    logic [RMIRQ_MODE_W-1:0]    mode_nxt;
    logic                       mode_valid_r;
    logic                       mode_valid_nxt;
    logic [RMIRQ_NUM_LINES-1:0] pend_r;
    logic [RMIRQ_NUM_LINES-1:0] pend_nxt;
    logic                       wake_r;
    logic                       wake_nxt;
    logic                       chip_rst_r;
    logic                       chip_rst_nxt;
    logic [RMIRQ_PHASE_W-1:0]   phase_r;
    logic [RMIRQ_PHASE_W-1:0]   phase_nxt;
    logic [RMIRQ_NUM_LINES-1:0] raw_req;
    logic [RMIRQ_NUM_LINES-1:0] fall_vec;

    // ****************************************
    // Pin synchroniser
    // ****************************************
    // Two flops per line, first flop feeds only the second
    always_comb
    begin
        sync1_nxt = I_MODE_PINS;
        sync2_nxt = sync1_r;
        prev_nxt  = (state_r == RMIRQ_ST_RUN) ? sync2_r : RMIRQ_LINES_IDLE;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            sync1_r <= RMIRQ_LINES_IDLE;
            sync2_r <= RMIRQ_LINES_IDLE;
            prev_r  <= RMIRQ_LINES_IDLE;
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r  <= prev_nxt;
        end
    end

    // ****************************************
    // Reset sequencer and mode latch
    // ****************************************
    // Mode captured on second edge after reset release
    always_comb
    begin
        state_nxt      = state_r;
        mode_nxt       = mode_r;
        mode_valid_nxt = mode_valid_r;
        chip_rst_nxt   = 1'b0;
        case (state_r)
            RMIRQ_ST_RESET:
            begin
                chip_rst_nxt = 1'b1;
                state_nxt    = RMIRQ_ST_LATCH;
            end
            RMIRQ_ST_LATCH:
            begin
                mode_nxt       = I_MODE_PINS;
                mode_valid_nxt = 1'b1;
                state_nxt      = RMIRQ_ST_RUN;
            end
            RMIRQ_ST_RUN:
            begin
                state_nxt = RMIRQ_ST_RUN;
            end
            default:
            begin
                state_nxt = RMIRQ_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            state_r      <= RMIRQ_ST_RESET;
            mode_r       <= RMIRQ_MODE_RST;
            mode_valid_r <= 1'b0;
            chip_rst_r   <= 1'b1;
        end
        else
        begin
            state_r      <= state_nxt;
            mode_r       <= mode_nxt;
            mode_valid_r <= mode_valid_nxt;
            chip_rst_r   <= chip_rst_nxt;
        end
    end

    // ****************************************
    // Phase generator
    // ****************************************
    // Free running, restarted by reset
    always_comb
    begin
        phase_nxt = RMIRQ_PHASE_W'(phase_r + 2'h1);   // Wraps on purpose
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            phase_r <= RMIRQ_PHASE_RST;
        else
            phase_r <= phase_nxt;
    end

    // ****************************************
    // Interrupt requests and wake
    // ****************************************
    // Level or edge per line, masked, set wins over ack
    always_comb
    begin
        raw_req  = '0;
        fall_vec = fall_det(prev_r, sync2_r);
        pend_nxt = pend_r;
        wake_nxt = 1'b0;
        if (state_r == RMIRQ_ST_RUN)
        begin
            for (int i = 0; i < RMIRQ_NUM_LINES; i++)
            begin
                if (I_CFG.edge_mode[i])
                    raw_req[i] = fall_vec[i];
                else
                    raw_req[i] = ~sync2_r[i];
            end
            for (int i = 0; i < RMIRQ_NUM_LINES; i++)
            begin
                if (I_CFG.edge_mode[i])
                    pend_nxt[i] = (pend_r[i] & ~I_INT_ACK[i]) | (raw_req[i] & I_CFG.enable[i]);
                else
                    pend_nxt[i] = raw_req[i] & I_CFG.enable[i];
            end
            // Line one wakes stop or wait; others wake wait only
            wake_nxt = (raw_req[RMIRQ_FIRST_LINE] & (I_STANDBY.in_stop | I_STANDBY.in_wait))
                     | ((|raw_req[RMIRQ_NUM_LINES-1:1]) & I_STANDBY.in_wait);
        end
        else
        begin
            pend_nxt = '0;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            pend_r <= '0;
            wake_r <= 1'b0;
        end
        else
        begin
            pend_r <= pend_nxt;
            wake_r <= wake_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign O_OP_MODE    = mode_r;
    assign O_MODE_VALID = mode_valid_r;
    assign O_INT_PEND   = pend_r;
    assign O_WAKE       = wake_r;
    assign O_CHIP_RESET = chip_rst_r;
    assign O_PHASE      = phase_r;

endmodule

// [tb/reset_mode_latch_ext_irq_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module reset_mode_latch_ext_irq_tb
    import rmirq_pkg::*;
;
    logic           clk = 1'b0;
    logic           rst_req = 1'b1;
    logic [3:0]     mode = 4'h0;
    logic [3:0]     req_n = 4'hF;
    logic [3:0]     ack = 4'h0;
    rmirq_cfg_t     cfg = '0;
    rmirq_standby_t sby = '0;
    logic           rst, valid, wake, chip_rst;
    logic [3:0]     pins, op_mode, pend, h0, h1, h2;
    logic [1:0]     phase;
    int             num_errors = 0;
    int             comparisons = 0;
    integer         seed = 32'hb56cea8d;
    // Clock and pin history
    always #2.5 clk = ~clk;
    always @(posedge clk) {h2, h1, h0} <= {h1, h0, pins};
    rmirq_src_model i_src (.i_clk(clk), .i_rst_req(rst_req), .i_mode(mode), .i_req_n(req_n),
        .o_rst(rst), .o_pins(pins));
    rmirq_top i_dut (.I_CLK(clk), .I_RST(rst), .I_MODE_PINS(pins), .I_CFG(cfg), .I_INT_ACK(ack),
        .I_STANDBY(sby), .O_OP_MODE(op_mode), .O_MODE_VALID(valid), .O_INT_PEND(pend),
        .O_WAKE(wake), .O_CHIP_RESET(chip_rst), .O_PHASE(phase));
    function automatic logic [3:0] exp_lvl(rmirq_cfg_t c, logic [3:0] p);
        return c.enable & ~c.edge_mode & ~p;
    endfunction
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic print_verdict;
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #50000;
        num_errors++;
        print_verdict;
    end
    // Every mode code, random requests, then edge and wake corners
    initial
    begin
        for (int m = 0; m < 16; m++)
        begin
            rst_req <= 1'b1;
            cyc(1);
            mode <= m[3:0];
            cfg <= rmirq_cfg_t'(8'((m == 15) ? 255 : $random(seed)));
            {sby, ack, req_n} <= 10'h00F;
            cyc(3);
            `CHK({chip_rst, phase, valid}, 4'h8)
            rst_req <= 1'b0;
            cyc(3);
            `CHK({valid, chip_rst, op_mode}, {2'b10, m[3:0]})
            if (m < 15)
                for (int i = 0; i < 40; i++)
                begin
                    req_n <= 4'($random(seed));
                    ack <= 4'($random(seed));
                    sby <= rmirq_standby_t'(2'($random(seed)));
                    cyc(1);
                    if (i > 3) `CHK(pend & ~cfg.edge_mode, exp_lvl(cfg, h2))
                end
            else
            begin
                sby <= 2'b10;
                req_n <= 4'hD;
                cyc(3);
                `CHK({pend, wake}, 5'h04)
                cyc(3);
                `CHK(pend, 4'h2)
                ack <= 4'h2;
                cyc(1);
                ack <= 4'h0;
                cyc(1);
                `CHK(pend, 4'h0)
                req_n <= 4'hC;
                cyc(3);
                `CHK({pend, wake}, 5'h03)
                sby <= 2'b01;
                req_n <= 4'hF;
                cyc(2);
                req_n <= 4'h7;
                cyc(3);
                `CHK(wake, 1'b1)
            end
        end
        print_verdict;
    end
endmodule

// [tb/rmirq_properties.sv]
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module rmirq_properties
    import rmirq_pkg::*;
(
    input wire logic           I_CLK,
    input wire logic           I_RST,
    input wire logic [3:0]     I_MODE_PINS,
    input wire rmirq_cfg_t     I_CFG,
    input wire logic [3:0]     I_INT_ACK,
    input wire rmirq_standby_t I_STANDBY,
    input wire logic [3:0]     O_OP_MODE,
    input wire logic           O_MODE_VALID,
    input wire logic [3:0]     O_INT_PEND,
    input wire logic           O_WAKE,
    input wire logic           O_CHIP_RESET,
    input wire logic [1:0]     O_PHASE
);
    default clocking dcb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    // Release sequence, mode capture and request sampling
    chk_reset_state:
        assert property ($fell(I_RST) |-> O_CHIP_RESET && O_PHASE == 2'h0 && !O_MODE_VALID
            ##1 O_CHIP_RESET && O_PHASE == 2'h1) else $error("bad release state");
    chk_mode_latch:
        assert property ($fell(I_RST) ##1 1'b1 |=> O_MODE_VALID && !O_CHIP_RESET
            && O_OP_MODE == $past(I_MODE_PINS)) else $error("bad mode capture");
    chk_level_pend:
        assert property ($past(O_MODE_VALID, 2) |-> (O_INT_PEND & ~$past(I_CFG.edge_mode))
            == ($past(I_CFG.enable & ~I_CFG.edge_mode) & ~$past(I_MODE_PINS, 3))) else $error("bad level pend");
    chk_edge_pend:
        assert property ($past(O_MODE_VALID, 2) |-> (~$past(I_MODE_PINS, 3) & $past(I_MODE_PINS, 4)
            & $past(I_CFG.enable & I_CFG.edge_mode) & ~O_INT_PEND) == 4'h0) else $error("edge missed");
    chk_edge_sticky:
        assert property (O_MODE_VALID |=> ($past(O_INT_PEND & I_CFG.edge_mode & ~I_INT_ACK) & ~O_INT_PEND)
            == 4'h0) else $error("edge pend lost");
    chk_stop_wake:
        assert property ($past(O_MODE_VALID, 2) && $past(I_STANDBY.in_stop) && !$past(I_MODE_PINS[0], 3)
            && $past(I_MODE_PINS[0], 4) |-> O_WAKE) else $error("no wake from stop");
    chk_wait_wake:
        assert property ($past(O_MODE_VALID, 2) && $past(I_STANDBY.in_wait)
            && |($past(I_MODE_PINS, 4) & ~$past(I_MODE_PINS, 3)) |-> O_WAKE) else $error("no wake from wait");
endmodule

bind rmirq_top rmirq_properties i_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_MODE_PINS(I_MODE_PINS),
    .I_CFG(I_CFG), .I_INT_ACK(I_INT_ACK), .I_STANDBY(I_STANDBY), .O_OP_MODE(O_OP_MODE),
    .O_MODE_VALID(O_MODE_VALID), .O_INT_PEND(O_INT_PEND), .O_WAKE(O_WAKE),
    .O_CHIP_RESET(O_CHIP_RESET), .O_PHASE(O_PHASE));

// [tb/rmirq_src_model.sv]
`timescale 1ns/1ps
// ****************************************
// Board reset and request sources
// ****************************************
module rmirq_src_model
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_req,
    input  wire logic [3:0] i_mode,
    input  wire logic [3:0] i_req_n,
    output logic            o_rst,
    output logic [3:0]      o_pins
);
    logic [2:0] hold_r = 3'h7;
    // Keeps the mode code on the pins past release
    always @(negedge i_clk) hold_r <= i_rst_req ? 3'h7 : hold_r >> 1;
    // Reset asserted from power-up
    assign o_rst = i_rst_req;
    assign o_pins = (i_rst_req || hold_r[0]) ? i_mode : i_req_n;
endmodule
